// ### verilog/pbch_defs.vh
/*
 * Constants for the primary bus control and release block.
 * Assumes inclusion by bare name from design files under verilog/.
 */
`ifndef PBCH_DEFS_VH
`define PBCH_DEFS_VH
`define PBCH_ADDR_W       24
`define PBCH_DATA_W       32
`define PBCH_RESET_VECTOR 24'h000000
`define PBCH_FLAG_GPIO    1'b0
`define PBCH_FLAG_ILOCK   1'b1
`define PBCH_RDY_SETTLE   2'h2
`endif

// ### verilog/pbch_sync2.v
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a slowly changing level, not a short pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module pbch_sync2 #(
    parameter [0:0] RESET_VAL = 1'b1
) (
    input  wire clk,
    input  wire reset_n,
    input  wire d_in,
    output wire q_out
);
    reg meta_q;   // First stage, read only by second
    reg sync_q;   // Second stage, safe to use

    // Two stages, constant reset value
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end
    assign q_out = sync_q;
endmodule
`default_nettype wire

// ### verilog/pbch_bus_ctrl.v
/*
 * Primary external bus control: strobe, direction, ready handshake,
 * bus release with acknowledge, shutdown tristate, interrupt acknowledge
 * and the two external flag pins.
 * Assumes an internal core issues access requests on the same clock and
 * that external pins (ready, release request, shutdown, flag inputs)
 * are asynchronous and go through synchronisers here.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pbch_defs.vh"
module pbch_bus_ctrl (
    input  wire                    clk,
    input  wire                    reset_n,
    // Core side
    input  wire                    acc_req,
    input  wire                    acc_read,
    input  wire [`PBCH_ADDR_W-1:0] acc_addr,
    input  wire [`PBCH_DATA_W-1:0] acc_wdata,
    output wire                    acc_ready,
    output reg                     acc_done,
    output reg  [`PBCH_DATA_W-1:0] acc_rdata,
    output wire                    core_run,
    output reg  [`PBCH_ADDR_W-1:0] start_addr,
    output reg                     start_pulse,
    input  wire                    int_ack_instr,
    input  wire                    ignore_release_request,
    input  wire [1:0]              flag_mode,
    input  wire [1:0]              flag_out,
    input  wire [1:0]              flag_oe,
    input  wire [1:0]              ilock_out,
    output wire [1:0]              flag_in,
    // External pins
    output reg  [`PBCH_ADDR_W-1:0] addr_bus_o,
    output wire                    addr_bus_oe,
    input  wire [`PBCH_DATA_W-1:0] data_bus_i,
    output reg  [`PBCH_DATA_W-1:0] data_bus_o,
    output wire                    data_bus_oe,
    output reg                     access_strobe_n_o,
    output wire                    access_strobe_n_oe,
    output reg                     rd_wr_n_o,
    output wire                    rd_wr_n_oe,
    input  wire                    ready_n,
    input  wire                    release_req_n,
    output reg                     bus_release_ack_n,
    output wire                    bus_release_ack_n_oe,
    output reg                     int_ack_out_n,
    output wire                    int_ack_out_n_oe,
    input  wire                    shutdown_tristate_n,
    input  wire                    ext_flag_0_i,
    output wire                    ext_flag_0_o,
    output wire                    ext_flag_0_oe,
    input  wire                    ext_flag_1_i,
    output wire                    ext_flag_1_o,
    output wire                    ext_flag_1_oe
);
    // One-hot states
    localparam [3:0] ST_IDLE = 4'h1;  // Bus driven, no access
    localparam [3:0] ST_ACC  = 4'h2;  // Strobe low, wait ready
    localparam [3:0] ST_REL  = 4'h4;  // Bus released
    localparam [3:0] ST_BACK = 4'h8;  // Ack gone, drive next cycle

    reg  [3:0] state_q;      // Bus state
    reg  [3:0] state_d;      // Next bus state
    reg        started_q;    // Vector fetch issued
    wire       ready_s;      // Synchronised ready, active low pin
    wire       rel_req_s;    // Synchronised release request
    wire       shz_s;        // Synchronised shutdown, active low
    wire [1:0] flag_s;       // Synchronised flag inputs
    wire       released;     // Bus lines floated by release
    wire       shut;         // Shutdown active
    wire       want_rel;     // Release request honoured
    reg  [1:0] acc_age_q;    // Edges spent in current access
    wire       acc_end;      // Access completes this edge

    // Control and flag pin inputs pass two flops; data_bus_i is sampled directly
    pbch_sync2 #(.RESET_VAL(1'b1)) u_rdy (.clk(clk), .reset_n(reset_n),
        .d_in(ready_n), .q_out(ready_s));
    pbch_sync2 #(.RESET_VAL(1'b1)) u_rel (.clk(clk), .reset_n(reset_n),
        .d_in(release_req_n), .q_out(rel_req_s));
    pbch_sync2 #(.RESET_VAL(1'b1)) u_shz (.clk(clk), .reset_n(reset_n),
        .d_in(shutdown_tristate_n), .q_out(shz_s));
    pbch_sync2 #(.RESET_VAL(1'b0)) u_xf0 (.clk(clk), .reset_n(reset_n),
        .d_in(ext_flag_0_i), .q_out(flag_s[0]));
    pbch_sync2 #(.RESET_VAL(1'b0)) u_xf1 (.clk(clk), .reset_n(reset_n),
        .d_in(ext_flag_1_i), .q_out(flag_s[1]));

    assign shut     = ~shz_s;
    assign want_rel = ~rel_req_s & ~ignore_release_request;
    // Floated in the withdraw cycle too, so the acknowledge is seen high
    // for a full cycle before the bus lines are driven again
    assign released = (state_q == ST_REL) | (state_q == ST_BACK);
    // Core is halted by shutdown and stalled while bus is held
    assign core_run  = started_q & ~shut;
    assign acc_ready = (state_q == ST_IDLE) & ~want_rel & ~shut;

    // Age of the current access in edges, saturating. A ready seen
    // through the synchroniser in the first two edges may still belong
    // to the previous access, so completion waits for the age to settle.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_age_q <= 2'h0;
        end else if (state_q != ST_ACC) begin
            acc_age_q <= 2'h0;
        end else if (acc_age_q != `PBCH_RDY_SETTLE) begin
            acc_age_q <= acc_age_q + 2'h1;
        end
    end
    // Fresh ready only, never a leftover from the last access
    assign acc_end = (state_q == ST_ACC) & ~ready_s &
                     (acc_age_q == `PBCH_RDY_SETTLE);

    // Next-state logic
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (want_rel) begin
                    state_d = ST_REL;
                end else if (acc_req && !shut) begin
                    state_d = ST_ACC;
                end
            end
            ST_ACC: begin
                // Finish the access before any release
                if (acc_end) begin
                    state_d = ST_IDLE;
                end
            end
            ST_REL: begin
                if (!want_rel) begin
                    state_d = ST_BACK;
                end
            end
            ST_BACK: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State, strobe, direction, acknowledge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q           <= ST_IDLE;
            access_strobe_n_o <= 1'b1;
            rd_wr_n_o         <= 1'b1;
            bus_release_ack_n <= 1'b1;
            addr_bus_o        <= {`PBCH_ADDR_W{1'b0}};
            data_bus_o        <= {`PBCH_DATA_W{1'b0}};
        end else begin
            state_q <= state_d;
            // Acknowledge follows release state; drops before drive
            bus_release_ack_n <= ~(state_d == ST_REL);
            if (state_q == ST_IDLE && state_d == ST_ACC) begin
                addr_bus_o        <= acc_addr;
                data_bus_o        <= acc_wdata;
                rd_wr_n_o         <= acc_read;
                access_strobe_n_o <= 1'b0;
            end else if (state_q == ST_ACC && state_d == ST_IDLE) begin
                access_strobe_n_o <= 1'b1;
                rd_wr_n_o         <= 1'b1;
            end
        end
    end

    // Read data capture and completion pulse
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_done  <= 1'b0;
            acc_rdata <= {`PBCH_DATA_W{1'b0}};
        end else begin
            acc_done <= acc_end;
            if (acc_end && rd_wr_n_o) begin
                acc_rdata <= data_bus_i;
            end
        end
    end

    // Start from reset vector once reset is gone
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            started_q   <= 1'b0;
            start_pulse <= 1'b0;
            start_addr  <= `PBCH_RESET_VECTOR;
        end else begin
            start_pulse <= ~started_q;
            started_q   <= 1'b1;
            start_addr  <= `PBCH_RESET_VECTOR;
        end
    end

    // Interrupt acknowledge, one cycle per instruction
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_ack_out_n <= 1'b1;
        end else begin
            int_ack_out_n <= ~(int_ack_instr & core_run);
        end
    end

    // Strobe stays driven high through reset so an external decoder
    // never sees a floating strobe as a false access
    // Enables: reset floats data, address, direction but not strobe
    assign addr_bus_oe          = reset_n & ~shut & ~released;
    assign data_bus_oe          = reset_n & ~shut & ~released &
                                  (state_q == ST_ACC) & ~rd_wr_n_o;
    assign rd_wr_n_oe           = reset_n & ~shut & ~released;
    assign access_strobe_n_oe   = ~shut & ~released;
    assign bus_release_ack_n_oe = ~shut;
    assign int_ack_out_n_oe     = ~shut;

    // Flags: GPIO or interlock; floated on shutdown and reset
    assign ext_flag_0_o  = (flag_mode[0] == `PBCH_FLAG_ILOCK) ?
                           ilock_out[0] : flag_out[0];
    assign ext_flag_1_o  = (flag_mode[1] == `PBCH_FLAG_ILOCK) ?
                           ilock_out[1] : flag_out[1];
    assign ext_flag_0_oe = reset_n & ~shut & flag_oe[0];
    assign ext_flag_1_oe = reset_n & ~shut & flag_oe[1];
    assign flag_in       = flag_s;
endmodule
`default_nettype wire

// ### verification/pbch_bus_ctrl_chk.sv
/* Checker for the bus control block, bound to its top-level ports.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module pbch_bus_ctrl_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        acc_read,
    input wire logic        acc_done,
    input wire logic        core_run,
    input wire logic        start_pulse,
    input wire logic [23:0] start_addr,
    input wire logic        int_ack_instr,
    input wire logic        int_ack_out_n,
    input wire logic        addr_bus_oe,
    input wire logic        data_bus_oe,
    input wire logic        access_strobe_n_o,
    input wire logic        access_strobe_n_oe,
    input wire logic        rd_wr_n_o,
    input wire logic        rd_wr_n_oe,
    input wire logic        ready_n,
    input wire logic        bus_release_ack_n,
    input wire logic        shutdown_tristate_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Completion flag lasts exactly one cycle
    sequence s_done; acc_done ##1 !acc_done; endsequence
    // Shutdown seen long enough to pass the synchroniser
    sequence s_shz; !shutdown_tristate_n [*3]; endsequence
    property p_dir; $fell(access_strobe_n_o) |-> rd_wr_n_o == $past(acc_read); endproperty
    a_dir: assert property (p_dir) else $error("direction wrong at access start");
    property p_rdy; $rose(access_strobe_n_o) |-> $past(ready_n, 3) == 1'h0; endproperty
    a_rdy: assert property (p_rdy) else $error("access ended without ready");
    property p_done; $rose(access_strobe_n_o) |-> s_done; endproperty
    a_done: assert property (p_done) else $error("no single done after strobe");
    property p_busy; !access_strobe_n_o && access_strobe_n_oe |-> bus_release_ack_n; endproperty
    a_busy: assert property (p_busy) else $error("bus released mid access");
    property p_float; !bus_release_ack_n |-> !(addr_bus_oe | data_bus_oe |
        access_strobe_n_oe | rd_wr_n_oe); endproperty
    a_float: assert property (p_float) else $error("bus driven while released");
    property p_back; $rose(bus_release_ack_n) |-> !addr_bus_oe && !access_strobe_n_oe; endproperty
    a_back: assert property (p_back) else $error("bus driven with ack drop");
    property p_int_ack_out_n; int_ack_instr && shutdown_tristate_n |=> !int_ack_out_n ##1 int_ack_out_n;
    endproperty
    a_int_ack_out_n: assert property (p_int_ack_out_n) else $error("interrupt ack pulse wrong");
    property p_shz; s_shz |-> !(addr_bus_oe | access_strobe_n_oe | core_run); endproperty
    a_shz: assert property (p_shz) else $error("pins driven in shutdown");
    property p_start; start_pulse |-> start_addr == 24'h000000 ##1 core_run; endproperty
    a_start: assert property (p_start) else $error("start not from vector");
endmodule
bind pbch_bus_ctrl pbch_bus_ctrl_chk u_chk (.*);
`default_nettype wire

// ### verification/pbch_mem_model.sv
/* Memory model answering strobe cycles with ready after a wait count.
   Assumes it may change its outputs just after the rising edge. */
`timescale 1ns/10ps
`default_nettype none
module pbch_mem_model (
    input wire logic        clk,
    input wire logic [3:0]  wait_cyc,
    input wire logic        strobe_n,
    input wire logic        strobe_oe,
    input wire logic        rd_wr_n,
    input wire logic [23:0] addr,
    input wire logic [31:0] wdata,
    output var logic        ready_n,
    output var logic [31:0] rdata
);
    logic [31:0] mem [0:15]; // Small store on low address bits
    int          cnt = 0;    // Cycles spent in this access
    initial ready_n = 1'h1;
    initial rdata = 32'h0;
    // Idle data bus toggles so no stale word looks valid
    always @(posedge clk) begin
        #1;
        if (strobe_oe && !strobe_n) begin
            if (cnt >= wait_cyc) begin
                ready_n = 1'h0;
                if (rd_wr_n) rdata = mem[addr[3:0]];
                else mem[addr[3:0]] = wdata;
            end
            cnt++;
        end else begin
            cnt = 0;
            ready_n = 1'h1;
            rdata = ~rdata;
        end
    end
endmodule
`default_nettype wire

// ### verification/pbch_bus_ctrl_tb.sv
/* Self-checking bench for the bus control block with a memory model.
   Assumes the checker binds itself to the block. */
`timescale 1ns/10ps
`default_nettype none
module pbch_bus_ctrl_tb;
    logic clk, reset_n, acc_req, acc_read, acc_ready, acc_done, core_run, start_pulse, ready_n;
    logic int_ack_instr, ignore_release_request, addr_bus_oe, data_bus_oe, release_req_n;
    logic access_strobe_n_o, access_strobe_n_oe, rd_wr_n_o, rd_wr_n_oe, shutdown_tristate_n;
    logic bus_release_ack_n, bus_release_ack_n_oe, int_ack_out_n, int_ack_out_n_oe;
    logic ext_flag_0_o, ext_flag_0_oe, ext_flag_1_o, ext_flag_1_oe;
    logic [1:0]  flag_in;
    logic [3:0]  wait_cyc; // Memory wait states
    logic [23:0] acc_addr, addr_bus_o, start_addr;
    logic [31:0] acc_wdata, acc_rdata, data_bus_i, data_bus_o;
    int          err_total = 0, comparisons = 0, cyc = 0;
    // Flags looped back, in plain output mode except for the interlock check in t_reset
    logic      [1:0] flag_mode, ilock_out;
    wire logic [1:0] flag_out = 2'h1, flag_oe = 2'h3;
    wire logic       ext_flag_0_i = ext_flag_0_o, ext_flag_1_i = ext_flag_1_o;
    pbch_bus_ctrl u_dut (.*);
    pbch_mem_model u_mem (.clk(clk), .wait_cyc(wait_cyc), .strobe_n(access_strobe_n_o),
        .strobe_oe(access_strobe_n_oe), .rd_wr_n(rd_wr_n_o), .addr(addr_bus_o),
        .wdata(data_bus_o), .ready_n(ready_n), .rdata(data_bus_i));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task chk(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task finish_test;
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Request held until done; bounded wait guards a hang
    task acc(logic rd, logic [23:0] a, logic [31:0] wd, logic [31:0] exp);
        int n;
        {acc_read, acc_addr, acc_wdata, acc_req} = {rd, a, wd, 1'h1};
        for (n = 0; n < 40 && acc_done !== 1'h1; n++) begin
            step();
            if (access_strobe_n_o === 1'h0) chk("dir", rd_wr_n_o, rd);
        end
        acc_req = 1'h0;
        chk("done", acc_done, 1'h1);
        if (rd) chk("rdata", acc_rdata, exp);
        step(); // Let done fall and the dropped request be seen
    endtask
    task t_reset;
        chk("in reset", {access_strobe_n_o, access_strobe_n_oe, rd_wr_n_oe, core_run}, 4'hc);
        reset_n = 1'h1;
        step();
        chk("start", {start_pulse, start_addr}, 25'h1000000);
        step();
        chk("run", core_run, 1'h1);
        chk("flags", {ext_flag_1_o, ext_flag_0_o, ext_flag_1_oe, ext_flag_0_oe}, 4'h7);
        chk("flag in", flag_in, 2'h1);
        {flag_mode, ilock_out} = 4'he;
        step();
        chk("interlock", {ext_flag_1_o, ext_flag_0_o}, 2'h2);
        flag_mode = 2'h0;
    endtask
    // Zero and long waits, written then read back
    task t_rw;
        for (int w = 0; w < 4; w += 3) begin
            wait_cyc = w[3:0];
            acc(1'h0, 24'h5 + w[23:0], 32'h5a5a0000 + w, 32'h0);
            acc(1'h1, 24'h5 + w[23:0], 32'h0, 32'h5a5a0000 + w);
        end
    endtask
    // Release asked for in mid access, then ignored, then withdrawn
    task t_release;
        wait_cyc = 4'h6;
        {acc_read, acc_addr, acc_wdata, acc_req} = {1'h0, 24'h2, 32'hbeef, 1'h1};
        step(2);
        release_req_n = 1'h0;
        step(4);
        chk("ack busy", bus_release_ack_n, 1'h1);
        acc(1'h0, 24'h2, 32'hbeef, 32'h0);
        step(3);
        chk("ack", bus_release_ack_n, 1'h0);
        chk("float", {addr_bus_oe, data_bus_oe, access_strobe_n_oe, rd_wr_n_oe, acc_ready}, 5'h0);
        ignore_release_request = 1'h1;
        acc(1'h1, 24'h2, 32'h0, 32'hbeef);
        ignore_release_request = 1'h0;
        release_req_n = 1'h1;
        step(5);
        chk("ack off", bus_release_ack_n, 1'h1);
        acc(1'h1, 24'h2, 32'h0, 32'hbeef);
    endtask
    task t_int_ack_out_n;
        int_ack_instr = 1'h1;
        step();
        int_ack_instr = 1'h0;
        chk("int_ack_out_n", int_ack_out_n, 1'h0);
        step();
        chk("int_ack_out_n end", int_ack_out_n, 1'h1);
    endtask
    // Shutdown floats all, then reset with it inactive recovers
    task t_shz;
        shutdown_tristate_n = 1'h0;
        step(4);
        chk("shz", {addr_bus_oe, data_bus_oe, access_strobe_n_oe, rd_wr_n_oe, bus_release_ack_n_oe,
            int_ack_out_n_oe, ext_flag_0_oe, ext_flag_1_oe, core_run}, 9'h0);
        shutdown_tristate_n = 1'h1;
        reset_n = 1'h0;
        step(2);
        t_reset();
    endtask
    // Hang guard well beyond the expected run
    always @(posedge clk) begin
        if (++cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        {acc_req, acc_read, int_ack_instr, ignore_release_request, reset_n} = 5'h0;
        {acc_addr, acc_wdata, wait_cyc, flag_mode, ilock_out} = 64'h0;
        {release_req_n, shutdown_tristate_n} = 2'h3;
        step(10);
        t_reset();
        t_rw();
        t_release();
        t_int_ack_out_n();
        t_shz();
        finish_test();
    end
endmodule
`default_nettype wire
